// ===== logic/idpm_pkg.sv
// Constants, register map and shared helpers of the priority map block
package idpm_pkg;

	// ****************************************************************
	// Map geometry
	// ****************************************************************
	localparam int MAP_BITS = 128;
	localparam int MAP_REGS = 16;
	localparam int FIELD_W = 2;
	localparam int FIELDS_PER_REG = 4;
	localparam int CODE_W = 6;
	localparam int CODE_MSB = 7;
	localparam int CODE_LSB = 2;

	// ****************************************************************
	// Register offsets and reset values
	// ****************************************************************
	localparam logic [7:0] MAP_BASE = 8'h60;
	localparam logic [7:0] IP_CLASS_PRIO_MAP_0 = 8'h60;
	localparam logic [7:0] IP_CLASS_PRIO_MAP_1 = 8'h61;
	localparam logic [7:0] IP_CLASS_PRIO_MAP_2 = 8'h62;
	localparam logic [7:0] IP_CLASS_PRIO_MAP_3 = 8'h63;
	localparam logic [7:0] IP_CLASS_PRIO_MAP_4 = 8'h64;
	localparam logic [7:0] IP_CLASS_PRIO_MAP_5 = 8'h65;
	localparam logic [7:0] IP_CLASS_PRIO_MAP_6 = 8'h66;
	localparam logic [7:0] MAP_LAST = 8'h6f;
	localparam logic [7:0] MAP_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	localparam logic [1:0] PRIO_RESET = 2'h0;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Six-bit code taken from a TOS or traffic-class byte
	function automatic logic [CODE_W-1:0] idpm_code_of(
		input logic [7:0] tc_byte
	);
		idpm_code_of = tc_byte[CODE_MSB:CODE_LSB];
	endfunction : idpm_code_of

	// Register index of a byte offset inside the map window
	function automatic logic [3:0] idpm_reg_index(
		input logic [7:0] addr
	);
		logic [7:0] diff;
		diff = addr - MAP_BASE;
		idpm_reg_index = diff[3:0];
	endfunction : idpm_reg_index

	// Offset lies inside the map window
	function automatic logic idpm_in_map(
		input logic [7:0] addr
	);
		idpm_in_map = (addr >= MAP_BASE) && (addr <= MAP_LAST);
	endfunction : idpm_in_map

endpackage : idpm_pkg

// ===== logic/idpm_field_select.sv
// Selects the two-bit map field addressed by a differentiated-services byte
`timescale 1ns/1ns
module idpm_field_select
	import idpm_pkg::*;
(
	// Map contents, field of code n at bits 2n+1:2n
	input wire logic [MAP_BITS-1:0] map_bits,
	// Byte from the IP header
	input wire logic [7:0] tc_byte,
	// Selected field
	output logic [FIELD_W-1:0] field
);

	// ****************************************************************
	// Decode
	// ****************************************************************
	wire logic [CODE_W-1:0] code;
	wire logic [CODE_W:0] bit_pos;

	// Low two bits of the byte take no part in the code
	assign code = idpm_code_of(tc_byte);
	assign bit_pos = {code, 1'b0};
	// Code 0 lands on bits 1-0 of the first register, rising linearly
	assign field = map_bits[bit_pos +: FIELD_W];

endmodule : idpm_field_select

// ===== logic/idpm_top.sv
// Priority map registers and per-frame priority lookup
//
// Overview of operation
// - Hold 128-bit map of sixty-four two-bit fields
// - Same lookup for IPv4 TOS, IPv6 class
// - Decode byte bits 7-2 into 64 codes
// - Priority equals field selected by the code
// - Code 0x00 selects bits 1-0 at 0x60
// - Four codes per byte, ascending bit pairs
// - Consecutive offsets each span 0x10 byte values
// - Map continues linearly, 0x6C at 0x66 bits 7-6
// - Fields read/write, reset to 00
`timescale 1ns/1ns
module idpm_top
	import idpm_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_ack,
	output logic reg_err,
	// Frame classification request
	input wire logic cls_valid,
	input wire logic cls_is_ip,
	input wire logic [7:0] cls_tc_byte,
	input wire logic [1:0] cls_default_prio,
	// Classification answer
	output logic prio_valid,
	output logic [1:0] prio_value,
	output logic prio_from_map
);

	// ****************************************************************
	// Reset release
	// ****************************************************************
	logic rst_meta_reg;
	logic rst_sync_reg;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
		end
	end

	// Only the second stage is used by the rest of the block
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_reg <= 1'b0;
		end else begin
			rst_sync_reg <= rst_meta_reg;
		end
	end

	wire logic rst_int_n;
	assign rst_int_n = rst_sync_reg;

	// ****************************************************************
	// Address decode
	// ****************************************************************
	wire logic addr_hit;
	wire logic [3:0] addr_idx;
	wire logic wr_hit;
	wire logic rd_hit;
	wire logic access;

	// One byte register per offset, 0x60 upward without gaps
	assign addr_hit = idpm_in_map(reg_addr);
	assign addr_idx = idpm_reg_index(reg_addr);
	assign wr_hit = reg_wr && addr_hit;
	assign rd_hit = reg_rd && addr_hit;
	assign access = reg_wr || reg_rd;

	// ****************************************************************
	// Map storage
	// ****************************************************************
	logic [7:0] map_reg [MAP_REGS];
	logic [7:0] map_next [MAP_REGS];
	wire logic [MAP_BITS-1:0] map_flat;
	// One write enable per register
	wire logic [MAP_REGS-1:0] wr_sel;

	genvar gi;
	generate
		for (gi = 0; gi < MAP_REGS; gi++) begin : g_map
			assign wr_sel[gi] = wr_hit && (addr_idx == 4'(gi));
			// Software write replaces the whole byte of four fields
			assign map_next[gi] = wr_sel[gi] ?
				reg_wdata : map_reg[gi];

			always_ff @(posedge mclk or negedge rst_int_n) begin
				if (!rst_int_n) begin
					map_reg[gi] <= MAP_RESET;
				end else begin
					map_reg[gi] <= map_next[gi];
				end
			end

			// Register n holds codes 4n..4n+3 in ascending bit pairs
			assign map_flat[gi*8 +: 8] = map_reg[gi];
		end
	endgenerate

	// ****************************************************************
	// Register read side
	// ****************************************************************
	logic [7:0] rdata_reg;
	logic ack_reg;
	logic err_reg;
	wire logic [7:0] rd_sel;
	wire logic [7:0] rdata_next;
	wire logic ack_next;
	wire logic err_next;

	// Reads see the value before a write in the same cycle
	assign rd_sel = map_reg[addr_idx];
	// Read data holds until the next read
	assign rdata_next = rd_hit ? rd_sel :
		(reg_rd ? UNMAPPED_READ : rdata_reg);
	assign ack_next = access;
	// Offsets outside the map are answered but flagged
	assign err_next = access && !addr_hit;

	always_ff @(posedge mclk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			rdata_reg <= MAP_RESET;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	always_ff @(posedge mclk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= ack_next;
		end
	end

	always_ff @(posedge mclk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			err_reg <= 1'b0;
		end else begin
			err_reg <= err_next;
		end
	end

	// ****************************************************************
	// Frame lookup
	// ****************************************************************
	wire logic [FIELD_W-1:0] map_field;

	// TOS and traffic-class bytes share one path, no version split
	idpm_field_select u_select (
		.map_bits(map_flat),
		.tc_byte(cls_tc_byte),
		.field(map_field)
	);

	logic pvalid_reg;
	logic [1:0] pvalue_reg;
	logic pmap_reg;
	wire logic map_used;
	wire logic pvalid_next;
	wire logic [1:0] pvalue_next;
	wire logic pmap_next;

	// Frames without an IP header keep the priority from elsewhere
	assign map_used = cls_valid && cls_is_ip;
	assign pvalid_next = cls_valid;
	assign pvalue_next = !cls_valid ? pvalue_reg :
		(cls_is_ip ? map_field : cls_default_prio);
	assign pmap_next = map_used;

	// Answer one cycle after each request
	always_ff @(posedge mclk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			pvalid_reg <= 1'b0;
		end else begin
			pvalid_reg <= pvalid_next;
		end
	end

	always_ff @(posedge mclk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			pvalue_reg <= PRIO_RESET;
		end else begin
			pvalue_reg <= pvalue_next;
		end
	end

	always_ff @(posedge mclk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			pmap_reg <= 1'b0;
		end else begin
			pmap_reg <= pmap_next;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Every output is a flop with no logic after it
	assign reg_rdata = rdata_reg;
	assign reg_ack = ack_reg;
	assign reg_err = err_reg;
	assign prio_valid = pvalid_reg;
	assign prio_value = pvalue_reg;
	assign prio_from_map = pmap_reg;

endmodule : idpm_top

// ===== dv/idpm_monitor.sv
// Port checks of the priority map block
`timescale 1ns/1ns
module idpm_monitor (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_ack,
	input wire logic reg_err,
	// Classification
	input wire logic cls_valid,
	input wire logic cls_is_ip,
	input wire logic [7:0] cls_tc_byte,
	input wire logic [1:0] cls_default_prio,
	input wire logic prio_valid,
	input wire logic [1:0] prio_value,
	input wire logic prio_from_map
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_ack_follows: assert property ((reg_wr || reg_rd) |=> reg_ack)
		else $error("register ack missing");
	a_err_range: assert property ((reg_wr || reg_rd) &&
		(reg_addr > 8'h6f || reg_addr < 8'h60)
		|=> reg_err) else $error("error flag missing");
	a_read_back: assert property (reg_wr && reg_addr[7:4] == 4'h6
		##2 reg_rd && reg_addr == $past(reg_addr, 2)
		|=> reg_rdata == $past(reg_wdata, 3)) else $error("read back wrong");
	a_ans_follows: assert property (cls_valid |=> prio_valid)
		else $error("answer missing");
	a_no_spurious: assert property (prio_valid |-> $past(cls_valid))
		else $error("answer without request");
	a_non_ip: assert property (cls_valid && !cls_is_ip |=> !prio_from_map
		&& prio_value == $past(cls_default_prio)) else $error("non-IP wrong");
	a_ip_map: assert property (cls_valid && cls_is_ip |=> prio_from_map)
		else $error("map not used");
	a_prio_hold: assert property (!cls_valid |=> $stable(prio_value))
		else $error("priority changed");
	a_write_next: assert property (reg_wr && reg_addr == 8'h60
		##1 cls_valid && cls_is_ip && cls_tc_byte[7:2] == 6'h00
		|=> prio_value == $past(reg_wdata[1:0], 2)) else $error("stale map");
endmodule : idpm_monitor
bind idpm_top idpm_monitor mon (.*);

// ===== dv/idpm_cls_src.sv
// Ingress classifier stand-in that issues lookup requests
`timescale 1ns/1ns
module idpm_cls_src (
	// Request to the map
	output logic cls_valid,
	output logic cls_is_ip,
	output logic [7:0] cls_tc_byte,
	output logic [1:0] cls_default_prio
);
	initial put(0, 0, 8'h00, 2'h0);
	task put(logic v, ip, logic [7:0] b, logic [1:0] d);
		cls_valid <= v;
		cls_is_ip <= ip;
		cls_tc_byte <= b;
		cls_default_prio <= d;
	endtask : put
endmodule : idpm_cls_src

// ===== dv/tb_top.sv
// Self-checking bench of the priority map block
`timescale 1ns/1ns
module tb_top;
	logic mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, cls_tc_byte, q;
	logic reg_ack, reg_err, cls_valid, cls_is_ip, prio_valid, prio_from_map;
	logic [1:0] cls_default_prio, prio_value;
	logic [7:0] shadow [16];
	int mismatches = 0, n_checks = 0, cyc = 0;
	always #4 mclk = ~mclk;
	idpm_top dut (.*);
	idpm_cls_src src (.*);
	task chk(logic [7:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task test_done;
		if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : test_done
	task rw(logic w, logic [7:0] a, d);
		@(posedge mclk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 0;
		reg_rd <= 0;
		#1 q = reg_rdata;
		chk(reg_ack, 1);
		chk(reg_err, a < 8'h60 || a > 8'h6f);
	endtask : rw
	task cls(logic ip, logic [7:0] b, logic [1:0] d, exp);
		@(posedge mclk);
		src.put(1, ip, b, d);
		@(posedge mclk);
		src.put(0, !ip, ~b, ~d);
		#1 chk(prio_value, exp);
		chk(prio_from_map, ip);
		chk(prio_valid, 1);
	endtask : cls
	task t_reset;
		for (int i = 0; i < 17; i++) begin
			rw(0, 8'(8'h60 + i), 8'h00);
			chk(q, 8'h00);
		end
		rw(0, 8'h5f, 8'h00);
		chk(q, 8'h00);
	endtask : t_reset
	task t_map;
		for (int i = 0; i < 16; i++) begin
			shadow[i] = 8'(i * 8'h1b) ^ 8'h93;
			rw(1, 8'(8'h60 + i), shadow[i]);
			rw(0, 8'(8'h60 + i), 8'h00);
			chk(q, shadow[i]);
		end
		for (int c = 0; c < 64; c++)
			cls(1, 8'({c, 2'(c)}), 2'h3, shadow[c/4][2*(c%4)+:2]);
	endtask : t_map
	task t_nonip;
		for (int d = 0; d < 4; d++)
			cls(0, 8'h00, 2'(d), 2'(d));
	endtask : t_nonip
	task t_order;
		shadow[0] = shadow[0] ^ 8'h01;
		@(posedge mclk);
		reg_wr <= 1;
		reg_addr <= 8'h60;
		reg_wdata <= shadow[0];
		src.put(1, 1, 8'h03, 2'h0);
		@(posedge mclk);
		reg_wr <= 0;
		#1 chk(prio_value, shadow[0][1:0] ^ 2'h1);
		@(posedge mclk);
		src.put(0, 0, 8'hfc, 2'h3);
		#1 chk(prio_value, shadow[0][1:0]);
	endtask : t_order
	always @(posedge mclk) begin
		cyc++;
		if (cyc > 2000) begin
			mismatches++;
			test_done;
		end
	end
	initial begin
		repeat (4) @(posedge mclk);
		rst_n <= 1;
		repeat (3) @(posedge mclk);
		t_reset;
		t_map;
		t_nonip;
		t_order;
		test_done;
	end
endmodule : tb_top
